// file: core/dsr_dev.sv
// register map end of the serial control link
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - every location is eight bits, bit7 MSB
// - defaults read from bit7 downward
// - reference select resets to 0xc0
// - host writes zeros into unused bits
// - host never writes fully open locations
// - any reset loads listed default values
// - shadowed writes only change holding copy
// - writing 0x01 to 0xff commits settings
// - commit copies all, transfer bit self-clears
// - local writes go to selected channels
// - host selects one channel before reading
// - both selected on read returns channel A
// - channel select ignored by global registers
// - 16-bit instruction then eight-bit data bytes
// - shift MSB first until changed
module dsr_dev #(
  parameter logic [7:0] CHIP_IDENTIFIER = 8'h5a, // arbitrary value
  parameter logic [1:0] GRADE   = 2'h3   // arbitrary value
) (
  // clock and reset
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_srst,
  // serial link
  dsr_spi_if.dev                                    spi,
  // settings in force, per entry and channel (0 = A, 1 = B)
  output logic [dsr_pkg::SHD_N-1:0][1:0][7:0]       o_active,
  output logic [7:0]                                o_feature,
  output logic                                      o_lsb_first
);

  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_SKIP} dsr_dev_st_e;

  // pin order in the synchroniser: 2 = sdio, 1 = csb_n, 0 = sclk
  logic [2:0] pin_in;
  logic [2:0] sy1_q;
  logic [2:0] sy2_q;
  logic [2:0] sy3_q;
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;

  dsr_dev_st_e st_q;
  logic [3:0]  cnt_q;
  logic [14:0] sh_q;
  logic [12:0] addr_q;
  logic        rd_q;
  logic [2:0]  nb_q;
  logic [7:0]  tx_q;
  logic        sdo_q;
  logic        sdo_oe_q;

  logic        lsb_q;
  logic        srst_q;
  logic [1:0]  csel_q;
  logic        xfer_q;
  logic [dsr_pkg::SHD_N-1:0][1:0][7:0] shd_q;
  logic [dsr_pkg::SHD_N-1:0][7:0]      shd_rd;
  logic [dsr_pkg::SHD_N-1:0][1:0]      shd_we;

  // pins come from another clock: three flops, edge once stages two and three agree
  assign pin_in = {spi.sdio, spi.csb_n, spi.sclk};
  assign lvl_d  = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & lvl_q);

  // reset to the idle levels (sdio and csb_n high, sclk low) so no false edge follows reset
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sy1_q <= 3'h6;
      sy2_q <= 3'h6;
      sy3_q <= 3'h6;
      lvl_q <= 3'h6;
    end else begin
      sy1_q <= pin_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      lvl_q <= lvl_d;
    end
  end

  // link events
  wire sclk_rise = lvl_d[0] & ~lvl_q[0];
  wire sclk_fall = ~lvl_d[0] & lvl_q[0];
  wire sel       = ~lvl_d[1];
  wire sdi       = lvl_d[2];

  // frame decode; order reversal keeps one shift direction for both modes
  wire        instr_last = cnt_q == 4'(dsr_pkg::INSTR_BITS - 1);
  wire        byte_last  = cnt_q == 4'(dsr_pkg::DATA_BITS - 1);
  wire        instr_done = sel & sclk_rise & (st_q == ST_INSTR) & instr_last;
  wire        byte_done  = sel & sclk_rise & (st_q == ST_DATA) & byte_last;
  wire [15:0] rx16       = {sh_q, sdi};
  wire [15:0] instr      = lsb_q ? dsr_pkg::rev16(rx16) : rx16;
  wire [7:0]  rx8        = {sh_q[6:0], sdi};
  wire [7:0]  wdat       = lsb_q ? dsr_pkg::rev8(rx8) : rx8;
  wire [12:0] nxt_addr   = addr_q + 13'h1;
  wire [2:0]  nb_last    = instr[14:13] == 2'h3 ? 3'h3 : {1'b0, instr[14:13]};
  wire        wr_stb     = byte_done & ~rd_q;

  // register decode for the write side
  wire [3:0] wr_find = dsr_pkg::shd_find(addr_q);
  wire       wr_port = wr_stb & (addr_q == dsr_pkg::ADDR_PORT);
  wire       wr_csel = wr_stb & (addr_q == dsr_pkg::ADDR_CSEL);
  wire       wr_xfer = wr_stb & (addr_q == dsr_pkg::ADDR_XFER);
  wire       wr_dfc  = wr_stb & (addr_q == dsr_pkg::ADDR_DFC);

  // read side: first byte uses the fresh instruction, later bytes walk upward
  wire [12:0] rd_addr = instr_done ? instr[12:0] : nxt_addr;
  wire [3:0]  rd_find = dsr_pkg::shd_find(rd_addr);
  wire [7:0]  port_rd = {1'b0, lsb_q, srst_q, 1'b1, 1'b1, srst_q, lsb_q, 1'b0};
  wire [7:0]  rd_val  =
    (rd_addr == dsr_pkg::ADDR_PORT) ? port_rd :
    (rd_addr == dsr_pkg::ADDR_ID)   ? CHIP_IDENTIFIER :
    (rd_addr == dsr_pkg::ADDR_GRD)  ? {2'h0, GRADE, 4'h0} :
    (rd_addr == dsr_pkg::ADDR_CSEL) ? {6'h0, csel_q} :
    (rd_addr == dsr_pkg::ADDR_XFER) ? {7'h0, xfer_q} :
    (rd_addr == dsr_pkg::ADDR_DFC)  ? o_feature :
    rd_find[3]                      ? shd_rd[rd_find[2:0]] : 8'h00;

  // frame state machine; csb_n high ends any frame and frees the data wire
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !sel) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 4'h0;
      rd_q   <= 1'b0;
      nb_q   <= 3'h0;
      sh_q   <= 15'h0;
      addr_q <= 13'h0;
    end else if (sclk_rise) begin
      sh_q  <= rx16[14:0];
      cnt_q <= cnt_q + 4'h1;
      case (st_q)
        ST_IDLE, ST_INSTR: begin
          st_q <= ST_INSTR;
          if (instr_done) begin
            st_q   <= ST_DATA;
            cnt_q  <= 4'h0;
            rd_q   <= instr[dsr_pkg::INSTR_RW];
            addr_q <= instr[12:0];
            nb_q   <= nb_last;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            cnt_q  <= 4'h0;
            addr_q <= nxt_addr;
            nb_q   <= nb_q - 3'h1;
            // W field of 11 streams until csb_n rises
            if (nb_q == 3'h0) begin
              st_q <= ST_SKIP;
            end else if (nb_q == 3'h3) begin
              nb_q <= 3'h3;
            end
          end
        end
        ST_SKIP: begin
          cnt_q <= 4'h0;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read data leaves on falling sclk so the host samples a settled bit
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !sel) begin
      tx_q     <= 8'h00;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (rd_q && (instr_done || byte_done)) begin
      tx_q <= rd_val;
    end else if (instr_done && instr[dsr_pkg::INSTR_RW]) begin
      tx_q <= rd_val;
    end else if (sclk_fall && st_q == ST_DATA && rd_q) begin
      sdo_oe_q <= 1'b1;
      sdo_q    <= lsb_q ? tx_q[0] : tx_q[7];
      tx_q     <= lsb_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end
  end

  assign spi.dev_sdio_o  = sdo_q;
  assign spi.dev_sdio_oe = sdo_oe_q;

  // global control registers; a pending soft reset takes them back one cycle later
  always_ff @(posedge i_core_clk) begin
    if (i_srst || srst_q) begin
      lsb_q     <= dsr_pkg::PORT_RST[dsr_pkg::PORT_LSB_HI];
      srst_q    <= 1'b0;
      csel_q    <= dsr_pkg::CSEL_RST;
      o_feature <= dsr_pkg::DFC_RST;
    end else begin
      if (wr_port) begin
        lsb_q  <= wdat[dsr_pkg::PORT_LSB_HI] | wdat[dsr_pkg::PORT_LSB_LO];
        srst_q <= wdat[dsr_pkg::PORT_SRS_HI] | wdat[dsr_pkg::PORT_SRS_LO];
      end
      if (wr_csel) begin
        csel_q <= wdat[1:0];
      end
      if (wr_dfc) begin
        o_feature <= wdat;
      end
    end
  end

  // transfer bit: a new set wins over the self-clear of the last commit
  always_ff @(posedge i_core_clk) begin
    if (i_srst || srst_q) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= wr_xfer & wdat[0];
    end
  end

  assign o_lsb_first = lsb_q;

  // shadowed entries: holding copy per channel plus the copy in force
  for (genvar g = 0; g < dsr_pkg::SHD_N; g++) begin : g_shd
    for (genvar c = 0; c < 2; c++) begin : g_ch
      // global entries ignore channel select and keep both copies equal
      assign shd_we[g][c] = wr_stb & wr_find[3] & (wr_find[2:0] == 3'(g)) &
                            (csel_q[c] | ~dsr_pkg::SHD_LOCAL[g]);
      always_ff @(posedge i_core_clk) begin
        if (i_srst || srst_q) begin
          shd_q[g][c]    <= dsr_pkg::SHD_RST[g];
          o_active[g][c] <= dsr_pkg::SHD_RST[g];
        end else begin
          if (shd_we[g][c]) begin
            shd_q[g][c] <= wdat;
          end
          if (xfer_q) begin
            o_active[g][c] <= shd_q[g][c];
          end
        end
      end
    end
    // channel A answers for global entries, or when channel A is selected; local entries answer from B otherwise (B or neither)
    assign shd_rd[g] = (csel_q[0] | ~dsr_pkg::SHD_LOCAL[g]) ?
                       shd_q[g][0] : shd_q[g][1];
  end

endmodule : dsr_dev
`default_nettype wire

// file: core/dsr_pkg.sv
// shared constants and helpers for the dual-channel register map and its serial host
package dsr_pkg;

  // register locations
  localparam logic [12:0] ADDR_PORT = 13'h000;
  localparam logic [12:0] ADDR_ID   = 13'h001;
  localparam logic [12:0] ADDR_GRD  = 13'h002;
  localparam logic [12:0] ADDR_CSEL = 13'h005;
  localparam logic [12:0] ADDR_XFER = 13'h0ff;
  localparam logic [12:0] ADDR_DFC  = 13'h100;

  // values after reset
  localparam logic [7:0] PORT_RST = 8'h18;
  localparam logic [1:0] CSEL_RST = 2'h3;
  localparam logic [7:0] DFC_RST  = 8'h00;

  // port configuration field positions (mirrored pairs)
  localparam int unsigned PORT_LSB_HI = 6;
  localparam int unsigned PORT_LSB_LO = 1;
  localparam int unsigned PORT_SRS_HI = 5;
  localparam int unsigned PORT_SRS_LO = 2;
  // speed grade field sits at bits 5:4
  localparam int unsigned GRD_POS = 4;

  // shadowed locations: index 0 is the lowest address
  localparam int unsigned SHD_N = 6;
  localparam logic [SHD_N-1:0][12:0] SHD_ADDR =
    {13'h030, 13'h018, 13'h00d, 13'h00b, 13'h009, 13'h008};
  localparam logic [SHD_N-1:0][7:0] SHD_RST =
    {8'h00, 8'hc0, 8'h00, 8'h00, 8'h01, 8'h80};
  // one bit per entry: set where each channel has its own copy
  localparam logic [SHD_N-1:0] SHD_LOCAL = 6'h09;

  // frame layout
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned INSTR_RW   = 15;

  // serial clock half period in core cycles
  localparam int unsigned SCLK_HALF = 8;

  // find a shadowed location: {hit, index}
  function automatic logic [3:0] shd_find(input logic [12:0] a);
    shd_find = 4'h0;
    for (int i = 0; i < SHD_N; i++) begin
      if (a == SHD_ADDR[i]) begin
        shd_find = {1'b1, 3'(i)};
      end
    end
  endfunction : shd_find

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7-i];
    end
  endfunction : rev8

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15-i];
    end
  endfunction : rev16

endpackage : dsr_pkg

// file: core/dsr_spi_if.sv
// three-wire serial control link between host and register map
`timescale 1ns/1ps
`default_nettype none
interface dsr_spi_if;
  logic sclk;
  logic csb_n;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;

  // resolved data wire; idles high as if pulled up
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

  modport host (output sclk, csb_n, host_sdio_o, host_sdio_oe, input sdio);
  modport dev  (input sclk, csb_n, sdio, output dev_sdio_o, dev_sdio_oe);
endinterface : dsr_spi_if
`default_nettype wire

// file: core/dsr_host.sv
// serial host end: one read or write of one byte per frame
`timescale 1ns/1ps
`default_nettype none
module dsr_host #(
  parameter int unsigned HALF = dsr_pkg::SCLK_HALF
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // user request
  input  wire logic        i_start,
  input  wire logic        i_read,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_lsb_first,
  // user answer
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  // serial link
  dsr_spi_if.host          spi
);

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LO, H_HI, H_TAIL, H_GAP} dsr_host_st_e;

  dsr_host_st_e st_q;
  logic [7:0]   tmr_q;
  logic [4:0]   bit_q;
  logic [23:0]  tx_q;
  logic [7:0]   rx_q;
  logic         rd_q;
  logic         lsb_q;
  logic         sclk_q;
  logic         csb_n_q;
  logic         sdo_q;
  logic         oe_q;
  logic [2:0]   sy_q;
  logic         lvl_q;

  // instruction: read flag, one-byte length, address; caller keeps open bits zero
  wire [15:0] instr   = {i_read, 2'b00, i_addr};
  wire [23:0] frame   = i_lsb_first ? {dsr_pkg::rev16(instr), dsr_pkg::rev8(i_wdata)} :
                                      {instr, i_wdata};
  wire        tmo     = tmr_q == 8'(HALF - 1);
  wire        last    = bit_q == 5'd23;
  wire [4:0]  nxt_bit = bit_q + 5'h1;
  // sdio returns from another clock: three flops, stages two and three must agree
  wire        lvl_d   = (sy_q[1] == sy_q[2]) ? sy_q[2] : lvl_q;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sy_q  <= 3'h7;
      lvl_q <= 1'b1;
    end else begin
      sy_q  <= {sy_q[1:0], spi.sdio};
      lvl_q <= lvl_d;
    end
  end

  // frame sequencer; sclk rests low, data changes while it is low
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q    <= H_IDLE;
      tmr_q   <= 8'h0;
      bit_q   <= 5'h0;
      tx_q    <= 24'h0;
      rx_q    <= 8'h0;
      rd_q    <= 1'b0;
      lsb_q   <= 1'b0;
      sclk_q  <= 1'b0;
      csb_n_q <= 1'b1;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 8'h0;
    end else begin
      o_done <= 1'b0;
      tmr_q  <= tmo ? 8'h0 : tmr_q + 8'h1;
      case (st_q)
        H_IDLE: begin
          tmr_q <= 8'h0;
          if (i_start) begin
            st_q    <= H_LEAD;
            tx_q    <= frame;
            rd_q    <= i_read;
            lsb_q   <= i_lsb_first;
            bit_q   <= 5'h0;
            csb_n_q <= 1'b0;
            o_busy  <= 1'b1;
          end
        end
        H_LEAD: begin
          if (tmo) begin
            st_q  <= H_LO;
            sdo_q <= tx_q[23];
            oe_q  <= 1'b1;
          end
        end
        H_LO: begin
          if (tmo) begin
            st_q   <= H_HI;
            sclk_q <= 1'b1;
          end
        end
        H_HI: begin
          if (tmo) begin
            sclk_q <= 1'b0;
            tx_q   <= {tx_q[22:0], 1'b0};
            bit_q  <= nxt_bit;
            // read bits are taken at the falling edge, well after the device drove them
            if (rd_q && bit_q[4]) begin
              rx_q <= {rx_q[6:0], lvl_d};
            end
            if (last) begin
              st_q <= H_TAIL;
            end else begin
              st_q  <= H_LO;
              sdo_q <= tx_q[22];
              // release the wire after the 16th instruction bit of a read
              oe_q  <= ~(rd_q & nxt_bit[4]);
            end
          end
        end
        H_TAIL: begin
          if (tmo) begin
            st_q    <= H_GAP;
            csb_n_q <= 1'b1;
            oe_q    <= 1'b0;
          end
        end
        H_GAP: begin
          if (tmo) begin
            st_q    <= H_IDLE;
            o_busy  <= 1'b0;
            o_done  <= 1'b1;
            o_rdata <= lsb_q ? dsr_pkg::rev8(rx_q) : rx_q;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign spi.sclk         = sclk_q;
  assign spi.csb_n        = csb_n_q;
  assign spi.host_sdio_o  = sdo_q;
  assign spi.host_sdio_oe = oe_q;

endmodule : dsr_host
`default_nettype wire

// file: test/dsr_link_properties.sv
// wire-level properties of the serial control link between host and register map
`timescale 1ns/1ps
`default_nettype none
module dsr_link_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // link signals
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  logic       sclk_q;
  logic [5:0] nrise_q;
  logic [5:0] nrise_d;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  // rising sclk edges inside the open frame; cleared while the frame is closed
  assign nrise_d = csb_n ? 6'h00 : nrise_q + {5'h00, sclk & ~sclk_q};
  always_ff @(posedge i_core_clk) begin
    sclk_q  <= i_srst ? 1'b0 : sclk;
    nrise_q <= i_srst ? 6'h00 : nrise_d;
  end

  // serial clock rests low outside frames, and host drives nothing then
  property p_sclk_idle; csb_n |-> !sclk; endproperty
  property p_hoe_idle; csb_n |-> !host_sdio_oe; endproperty
  // both ends driving at once would be a bus fight on the shared wire
  property p_one_drv; !(host_sdio_oe && dev_sdio_oe); endproperty
  // device lets go of the wire within the sync latency after the frame closes
  property p_dev_release; $rose(csb_n) |-> ##[0:8] !dev_sdio_oe; endproperty
  // half period is 8 core cycles with the default host setting
  property p_sclk_high; $rose(sclk) |-> sclk [*8] ##1 !sclk; endproperty
  property p_sclk_low; $fell(sclk) |-> !sclk [*8]; endproperty
  // data only moves while sclk is low, so the sampling edge sees it settled
  property p_hdat_stable; sclk && $past(sclk) |-> $stable(host_sdio_o); endproperty
  property p_ddat_stable;
    dev_sdio_oe && sclk && $past(sclk) |-> $stable(dev_sdio_o);
  endproperty
  // a single-byte frame is 16 instruction bits plus 8 data bits
  property p_frame_bits; $rose(csb_n) |-> nrise_q == 6'h18; endproperty
  // turnaround only after the full instruction
  property p_turn; $rose(dev_sdio_oe) |-> nrise_q == 6'h10; endproperty
  property p_host_turn;
    $fell(host_sdio_oe) && !csb_n |-> nrise_q == 6'h10;
  endproperty

  a_sclk_idle : assert property (p_sclk_idle) else $error("sclk moved outside a frame");
  a_hoe_idle : assert property (p_hoe_idle) else $error("host drives with frame closed");
  a_one_drv : assert property (p_one_drv) else $error("both ends drive the data wire");
  a_dev_release : assert property (p_dev_release) else $error("device held wire");
  a_sclk_high : assert property (p_sclk_high) else $error("sclk high phase wrong");
  a_sclk_low : assert property (p_sclk_low) else $error("sclk low phase too short");
  a_hdat_stable : assert property (p_hdat_stable) else $error("host data moved");
  a_ddat_stable : assert property (p_ddat_stable) else $error("device data moved");
  a_frame_bits : assert property (p_frame_bits) else $error("frame bit count wrong");
  a_turn : assert property (p_turn) else $error("device turned wire early or late");
  a_host_turn : assert property (p_host_turn) else $error("host released wire wrong");

  c_read : cover property ($rose(dev_sdio_oe));
  c_frame : cover property ($rose(csb_n));
  c_zero_read : cover property (dev_sdio_oe && !sdio);
endmodule : dsr_link_chk
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench: host end and register map joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected %s: expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  // defaults of the six shadowed entries, both channel copies
  localparam logic [5:0][1:0][7:0] DEF = 96'h0000_c0c0_0000_0000_0101_8080;
  logic                             clk   = 1'b0;
  logic                             srst  = 1'b1;
  logic                             start = 1'b0;
  logic                             rnw   = 1'b0;
  logic [12:0]                      addr  = 13'h000;
  logic [7:0]                       wdat  = 8'h00;
  logic                             lsb   = 1'b0;
  logic                             busy;
  logic                             done;
  logic [7:0]                       rdata;
  logic [dsr_pkg::SHD_N-1:0][1:0][7:0] active;
  logic [7:0]                       feature;
  logic                             lsb_act;
  logic [23:0]                      cap   = 24'h000000;
  logic [7:0]                       rd;
  int                               failures  = 0;
  int                               tests_run = 0;

  always #12.5 clk = ~clk;

  dsr_spi_if dsr_spi_if_i ();
  dsr_host dsr_host_i (.i_core_clk(clk), .i_srst(srst), .i_start(start), .i_read(rnw),
    .i_addr(addr), .i_wdata(wdat), .i_lsb_first(lsb), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .spi(dsr_spi_if_i.host));
  dsr_dev dsr_dev_i (.i_core_clk(clk), .i_srst(srst), .spi(dsr_spi_if_i.dev),
    .o_active(active), .o_feature(feature), .o_lsb_first(lsb_act));
  dsr_link_chk dsr_link_chk_i (.i_core_clk(clk), .i_srst(srst), .sclk(dsr_spi_if_i.sclk),
    .csb_n(dsr_spi_if_i.csb_n), .host_sdio_o(dsr_spi_if_i.host_sdio_o),
    .host_sdio_oe(dsr_spi_if_i.host_sdio_oe), .dev_sdio_o(dsr_spi_if_i.dev_sdio_o),
    .dev_sdio_oe(dsr_spi_if_i.dev_sdio_oe), .sdio(dsr_spi_if_i.sdio));

  // host bits taken at the same sclk edge the device samples them
  always @(posedge dsr_spi_if_i.sclk) begin
    if (dsr_spi_if_i.host_sdio_oe) cap <= {cap[22:0], dsr_spi_if_i.sdio};
  end

  // expected wire pattern of a write frame; lsb mode reverses instruction and byte apart
  function automatic logic [23:0] wexp(input logic [12:0] a, input logic [7:0] d,
                                       input logic l);
    logic [15:0] ins;
    ins = {3'h0, a};
    wexp = {ins, d};
    for (int i = 0; i < 16; i++) if (l) wexp[8+i] = ins[15-i];
    for (int i = 0; i < 8; i++) if (l) wexp[i] = d[7-i];
  endfunction : wexp

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one frame: request held one cycle, then wait for done under a bound
  task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    rnw = r;
    addr = a;
    wdat = d;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    `CHK("busy", 1'b1, busy)
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      $display("unexpected done: expected pulse seen timeout");
    end
    `CHK("busy", 1'b0, busy)
    rd = rdata;
  endtask : xfer

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
    `CHK("wire bits", wexp(a, d, lsb), cap)
  endtask : wr

  task automatic rdr(input logic [12:0] a);
    xfer(1'b1, a, 8'h00);
  endtask : rdr

  // a hang would stall the main sequence; about five times the expected run
  initial begin
    #2000000;
    failures++;
    $display("unexpected watchdog: expected done seen hang");
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    `CHK("active", DEF, active)
    `CHK("feature", 8'h00, feature)
    `CHK("lsb mode", 1'b0, lsb_act)
    rdr(13'h000); `CHK("port cfg", 8'h18, rd)
    rdr(13'h018); `CHK("ref sel", 8'hc0, rd)
    rdr(13'h001); `CHK("chip_identifier", 8'h5a, rd)
    rdr(13'h002); `CHK("grade", 8'h30, rd)
    rdr(13'h0ff); `CHK("commit", 8'h00, rd)
    rdr(13'h013); `CHK("open loc", 8'h00, rd)
    // read-only places keep their values after writes
    wr(13'h001, 8'hff); rdr(13'h001); `CHK("chip_identifier", 8'h5a, rd)
    wr(13'h002, 8'h10); rdr(13'h002); `CHK("grade", 8'h30, rd)
    // holding copy changes, setting in force waits for the commit
    wr(13'h018, 8'h40); `CHK("ref act", 16'hc0c0, active[4])
    rdr(13'h018); `CHK("ref hold", 8'h40, rd)
    wr(13'h0ff, 8'h01); `CHK("ref act", 16'h4040, active[4])
    rdr(13'h0ff); `CHK("commit", 8'h00, rd)
    // per-channel steering against global locations
    wr(13'h005, 8'h01); wr(13'h008, 8'h81);
    wr(13'h005, 8'h02); wr(13'h008, 8'h82); wr(13'h00b, 8'h03);
    wr(13'h005, 8'h03); wr(13'h00d, 8'h05);
    `CHK("pwr act", 16'h8080, active[0])
    wr(13'h0ff, 8'h01);
    `CHK("pwr act", 16'h8281, active[0])
    `CHK("test act", 16'h0505, active[3])
    `CHK("div act", 16'h0303, active[2])
    `CHK("ref act", 16'h4040, active[4])
    rdr(13'h008); `CHK("pwr both", 8'h81, rd)
    wr(13'h005, 8'h02); rdr(13'h008); `CHK("pwr b", 8'h82, rd)
    // unshadowed location takes effect at once
    wr(13'h100, 8'ha5); `CHK("feature", 8'ha5, feature)
    rdr(13'h100); `CHK("feature rd", 8'ha5, rd)
    // switch to lsb-first shifting, then traffic in the new order
    wr(13'h000, 8'h5a); `CHK("lsb mode", 1'b1, lsb_act)
    lsb = 1'b1;
    rdr(13'h000); `CHK("port cfg", 8'h5a, rd)
    wr(13'h00b, 8'h06); rdr(13'h00b); `CHK("div hold", 8'h06, rd)
    // soft reset from lsb mode restores every default
    wr(13'h000, 8'h3c);
    lsb = 1'b0;
    `CHK("active", DEF, active)
    `CHK("feature", 8'h00, feature)
    `CHK("lsb mode", 1'b0, lsb_act)
    rdr(13'h000); `CHK("port cfg", 8'h18, rd)
    rdr(13'h005); `CHK("chan sel", 8'h03, rd)
    rdr(13'h00b); `CHK("div hold", 8'h00, rd)
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
